/* design/mode_rec_pkg.sv */
// Purpose: constants for the receive/transmit mode command record writer
// Assumes: 16-bit shared RAM words, 32-bit AXI4-Lite register bus
// Notes: register addresses and response codes are shared with the bench
package mode_rec_pkg;
    // ----------------------------------------
    // Record layout
    // ----------------------------------------
    localparam int unsigned REC_TAG_OFS = 1;
    localparam int unsigned REC_DATA_OFS = 2;
    localparam logic [4:0] MC_FIRST_WITH_DATA = 5'h10;
    localparam logic [4:0] MC_RX_UNDEF_A = 5'h10;
    localparam logic [4:0] MC_RX_UNDEF_B = 5'h12;
    localparam logic [4:0] MC_RX_UNDEF_C = 5'h13;
    localparam logic [4:0] MC_TX_LAST_CMD = 5'h12;
    localparam logic [4:0] MC_TX_BIT_WORD = 5'h13;
    // ----------------------------------------
    // Status word bits
    // ----------------------------------------
    localparam int unsigned SW_INVALID_WORD = 14;
    localparam int unsigned SW_GAP_OR_BROADCAST_FLAG = 13;
    localparam int unsigned SW_WORD_COUNT = 12;
    localparam int unsigned SW_SYNC_TYPE = 11;
    localparam int unsigned SW_MSG_ERROR = 10;
    localparam int unsigned SW_BUSY = 9;
    localparam int unsigned SW_ILLEGAL = 8;
    localparam int unsigned SW_BUS = 5;
    // ----------------------------------------
    // Registers (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_LAST_STATUS = 8'h04;
    localparam logic [7:0] ADDR_REC_COUNT = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0C;
    localparam int unsigned CFG_UMC_INVALID = 0;
    localparam int unsigned CFG_GLOBAL_BUSY = 1;
    localparam int unsigned CFG_BCAST_SEL = 3;
    localparam logic [3:0] CONFIG_RESET = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_TAG = 2'b01,
        ST_DATA = 2'b10
    } wr_state_t;
endpackage : mode_rec_pkg

/* design/rt_mode_cmd_record_writer.sv */
// Purpose: write the status/time-tag/data record of each completed mode command
// Assumes: message fields are valid in the cycle msg_done is high and taken
// Notes: one RAM word is written per cycle, status word first
//
// How it works
// - Codes 0-15: status plus time tag only
// - Status word goes at data pointer
// - Codes 16-31: three words, one data word
// - Time tag at pointer plus one
// - Mode data word at pointer plus two
// - Received mode data may be acted upon
// - Record words written after message completion
// - Undefined rx codes 16,18,19 answered in form; the code answers them not in form when CFG_UMC_INVALID is set
// - Undefined rx codes 0-15 answered in form; the code answers them not in form when CFG_UMC_INVALID is set
// - Bit 14: bad Manchester or parity
// - Bit 13 gap error when gap mode
// - Bit 13 broadcast when broadcast mode
// - Bit 12: missing or extra word
// - Bit 11: wrong sync on data word
// - Bit 10: summary of bits 11, 12, 14, and of bit 13 in gap mode only
// - Bit 9: answered with busy status
// - Bit 8: illegalization bit was one
// - Bit 5: zero bus A, one bus B
// - Bits 4-0 copy the mode code
// - Pointer taken from command's descriptor
// - Tx codes 18,19 data made internally
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module rt_mode_cmd_record_writer #(
    parameter int unsigned ADDR_W = 13
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic msg_done,
    output logic msg_ready,
    input wire logic msg_is_tx,
    input wire logic [4:0] mode_code_field,
    input wire logic [15:0] cmd_word,
    input wire logic [ADDR_W-1:0] data_pointer,
    input wire logic [15:0] time_tag,
    input wire logic [15:0] mode_data_word,
    input wire logic [15:0] bit_word,
    input wire logic data_word_seen,
    input wire logic extra_word_seen,
    input wire logic data_word_bad,
    input wire logic data_sync_bad,
    input wire logic gap_seen,
    input wire logic broadcast,
    input wire logic bus_b,
    input wire logic illegal_bit,
    input wire logic per_command_busy,
    output logic respond_in_form,
    output logic answer_busy,
    output logic [15:0] tx_mode_data,
    output logic mode_data_strobe,
    output logic [4:0] mode_data_code,
    output logic [15:0] mode_data_value,
    output logic ram_we,
    output logic [ADDR_W-1:0] ram_addr,
    output logic [15:0] ram_wdata
);
    import mode_rec_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic has_data(input logic [4:0] mc);
        has_data = (mc >= MC_FIRST_WITH_DATA);
    endfunction : has_data

    function automatic logic rx_undefined(input logic [4:0] mc);
        rx_undefined = !has_data(mc) || mc == MC_RX_UNDEF_A || mc == MC_RX_UNDEF_B
            || mc == MC_RX_UNDEF_C;
    endfunction : rx_undefined

    wr_state_t state_reg;
    logic [3:0] config_reg;
    logic [15:0] status_reg;
    logic [15:0] last_status_reg;
    logic [15:0] tag_reg;
    logic [15:0] data_reg;
    logic [15:0] last_cmd_reg;
    logic [15:0] tx_data_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic with_data_reg;
    logic [31:0] rec_count_reg;
    logic [15:0] status_next;
    logic [15:0] tx_data_next;
    logic accept;
    logic err_any;
    logic aw_held, w_held;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    assign msg_ready = (state_reg == ST_IDLE);
    assign accept = msg_done && msg_ready;

    // ----------------------------------------
    // Response decision
    // ----------------------------------------
    // undefined rx codes in form unless CFG_UMC_INVALID is set
    assign respond_in_form = !illegal_bit
        && !(!msg_is_tx && rx_undefined(mode_code_field) && config_reg[CFG_UMC_INVALID]);
    assign answer_busy = config_reg[CFG_GLOBAL_BUSY] || per_command_busy;

    always_comb begin
        tx_data_next = mode_data_word;
        if (mode_code_field == MC_TX_LAST_CMD) begin
            tx_data_next = last_cmd_reg;
        end else if (mode_code_field == MC_TX_BIT_WORD) begin
            tx_data_next = bit_word;
        end
    end

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    assign err_any = (!msg_is_tx && (data_word_bad || data_sync_bad))
        || (data_word_seen != (has_data(mode_code_field) && !msg_is_tx)) || extra_word_seen
        || (!config_reg[CFG_BCAST_SEL] && gap_seen);

    always_comb begin
        status_next = 16'h0000;
        status_next[SW_INVALID_WORD] = !msg_is_tx && data_word_bad;
        status_next[SW_GAP_OR_BROADCAST_FLAG] = config_reg[CFG_BCAST_SEL] ? broadcast : gap_seen;
        status_next[SW_WORD_COUNT] = extra_word_seen
            || (data_word_seen != (!msg_is_tx && has_data(mode_code_field)));
        status_next[SW_SYNC_TYPE] = !msg_is_tx && data_sync_bad;
        status_next[SW_MSG_ERROR] = err_any;
        status_next[SW_BUSY] = answer_busy && respond_in_form;
        status_next[SW_ILLEGAL] = illegal_bit;
        status_next[SW_BUS] = bus_b;
        status_next[4:0] = mode_code_field;
    end

    // ----------------------------------------
    // Capture and record writer
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= 16'h0000;
            tag_reg <= 16'h0000;
            data_reg <= 16'h0000;
            ptr_reg <= '0;
            with_data_reg <= 1'b0;
            last_cmd_reg <= 16'h0000;
        end else if (accept) begin
            status_reg <= status_next;
            tag_reg <= time_tag;
            data_reg <= msg_is_tx ? tx_data_next : mode_data_word;
            ptr_reg <= data_pointer;
            with_data_reg <= has_data(mode_code_field);
            last_cmd_reg <= cmd_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= ST_IDLE;
            ram_we <= 1'b0;
            ram_addr <= '0;
            ram_wdata <= 16'h0000;
        end else begin
            ram_we <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept) begin
                        ram_we <= 1'b1;
                        ram_addr <= data_pointer;
                        ram_wdata <= status_next;
                        state_reg <= ST_TAG;
                    end
                end
                ST_TAG: begin
                    ram_we <= 1'b1;
                    ram_addr <= ptr_reg + ADDR_W'(REC_TAG_OFS);
                    ram_wdata <= tag_reg;
                    state_reg <= with_data_reg ? ST_DATA : ST_IDLE;
                end
                ST_DATA: begin
                    ram_we <= 1'b1;
                    ram_addr <= ptr_reg + ADDR_W'(REC_DATA_OFS);
                    ram_wdata <= data_reg;
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Mode data action and tx data
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_data_strobe <= 1'b0;
            mode_data_code <= 5'h00;
            mode_data_value <= 16'h0000;
            tx_mode_data <= 16'h0000;
            tx_data_reg <= 16'h0000;
            last_status_reg <= 16'h0000;
            rec_count_reg <= 32'h00000000;
        end else begin
            mode_data_strobe <= accept && !msg_is_tx && has_data(mode_code_field)
                && data_word_seen && !err_any && respond_in_form;
            if (accept) begin
                mode_data_code <= mode_code_field;
                mode_data_value <= mode_data_word;
                last_status_reg <= status_next;
                rec_count_reg <= rec_count_reg + 32'h00000001;
                if (msg_is_tx) begin
                    tx_mode_data <= tx_data_next;
                    tx_data_reg <= tx_data_next;
                end
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            config_reg <= CONFIG_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_held && w_held) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == ADDR_CONFIG) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (w_strb_reg[0]) begin
                        config_reg <= w_data_reg[3:0];
                    end
                end else if (aw_addr_reg == ADDR_LAST_STATUS || aw_addr_reg == ADDR_REC_COUNT
                    || aw_addr_reg == ADDR_TX_DATA) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_DECERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                ADDR_CONFIG: s_axi_rdata <= {28'h0000000, config_reg};
                ADDR_LAST_STATUS: s_axi_rdata <= {16'h0000, last_status_reg};
                ADDR_REC_COUNT: s_axi_rdata <= rec_count_reg;
                ADDR_TX_DATA: s_axi_rdata <= {16'h0000, tx_data_reg};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= RESP_DECERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_status_at_ptr;
        logic [ADDR_W-1:0] p;
        (accept, p = data_pointer) |=> ram_we && ram_addr == p;
    endproperty
    a_status_at_ptr: assert property (p_status_at_ptr) else $error("status not at pointer");

    property p_tag_next;
        logic [15:0] t;
        (accept, t = time_tag) |=> ##1 ram_we && ram_wdata == t && ram_addr == $past(ram_addr) + 1;
    endproperty
    a_tag_next: assert property (p_tag_next) else $error("time tag misplaced");

    property p_no_data_short;
        accept && mode_code_field < 5'h10 |=> ##1 msg_ready ##1 (!ram_we || $past(accept));
    endproperty
    a_no_data_short: assert property (p_no_data_short) else $error("short record too long");

    property p_data_third;
        accept && mode_code_field >= 5'h10 |=> ram_we [*3] ##0 ram_addr == $past(ram_addr, 2) + 2;
    endproperty
    a_data_third: assert property (p_data_third) else $error("data word misplaced");

    property p_no_write_idle;
        msg_ready && !$past(accept) |-> !ram_we || $past(state_reg) != ST_IDLE;
    endproperty
    a_no_write_idle: assert property (p_no_write_idle) else $error("write without message");

    property p_code_copy;
        accept |=> ram_wdata[4:0] == $past(mode_code_field) && ram_wdata[15] == 1'b0
            && ram_wdata[7:6] == 2'b00;
    endproperty
    a_code_copy: assert property (p_code_copy) else $error("code or unused bits wrong");

    property p_bus_bit;
        accept |=> ram_wdata[5] == $past(bus_b);
    endproperty
    a_bus_bit: assert property (p_bus_bit) else $error("bus bit wrong");

    property p_message_error_summary;
        accept |=> ram_wdata[10] == (ram_wdata[14] || ram_wdata[12] || ram_wdata[11]
            || (ram_wdata[13] && !$past(config_reg[CFG_BCAST_SEL])));
    endproperty
    a_message_error_summary: assert property (p_message_error_summary) else $error("error summary missing");

    property p_illegal;
        accept |=> ram_wdata[8] == $past(illegal_bit);
    endproperty
    a_illegal: assert property (p_illegal) else $error("illegal bit wrong");

    c_short: cover property (accept && mode_code_field < 5'h10);
    c_rx_data: cover property (accept && !msg_is_tx && mode_code_field >= 5'h10);
    c_tx_last: cover property (accept && msg_is_tx && mode_code_field == MC_TX_LAST_CMD);
    c_error: cover property (accept ##1 ram_wdata[10]);
endmodule : rt_mode_cmd_record_writer

/* tb/mode_cmd_source.sv */
// Purpose: bus controller side, hands completed mode messages to the writer
// Assumes: shares aclk with the writer
// Notes: fields are inverted once taken, so stale values never match
`timescale 1ns/100ps
module mode_cmd_source (
    input wire logic aclk,
    input wire logic msg_ready,
    input wire logic respond_in_form,
    input wire logic answer_busy,
    output logic msg_done,
    output logic msg_is_tx,
    output logic [4:0] mode_code_field,
    output logic [15:0] cmd_word,
    output logic [12:0] data_pointer,
    output logic [15:0] time_tag,
    output logic [15:0] mode_data_word,
    output logic [15:0] bit_word,
    output logic [8:0] flags,
    output logic rif_seen,
    output logic busy_seen,
    output logic timed_out
);
    initial begin
        {msg_done, msg_is_tx, mode_code_field, cmd_word, data_pointer} = '0;
        {time_tag, mode_data_word, bit_word, flags} = '0;
        {rif_seen, busy_seen, timed_out} = '0;
    end

    // ----
    // Message hand-over
    // ----
    task automatic send(input logic tx, input logic [4:0] mc, input logic [12:0] ptr,
        input logic [15:0] tag, input logic [15:0] dw, input logic [15:0] cw,
        input logic [15:0] bw, input logic [8:0] f, input int gap);
        logic rdy;
        int n;
        repeat (gap + 1) @(posedge aclk);
        msg_done <= 1'b1;
        msg_is_tx <= tx;
        mode_code_field <= mc;
        cmd_word <= cw;
        data_pointer <= ptr;
        time_tag <= tag;
        mode_data_word <= dw;
        bit_word <= bw;
        flags <= f;
        rdy = 1'b0;
        for (n = 0; n < 100 && !rdy; n++) begin
            @(negedge aclk);
            rdy = msg_ready;
            rif_seen <= respond_in_form;
            busy_seen <= answer_busy;
            @(posedge aclk);
        end
        if (!rdy) timed_out = 1'b1;
        msg_done <= 1'b0;
        {msg_is_tx, mode_code_field, cmd_word} <= ~{tx, mc, cw};
        {data_pointer, time_tag, mode_data_word, bit_word, flags} <= ~{ptr, tag, dw, bw, f};
    endtask : send
endmodule : mode_cmd_source

/* tb/test_rt_mode_cmd_record_writer.sv */
// Purpose: self-checking bench for the mode command record writer
// Assumes: default ADDR_W of 13
// Notes: RAM writes are checked against a queue of expected words
`timescale 1ns/100ps
module test_rt_mode_cmd_record_writer;
    import mode_rec_pkg::*;
    typedef struct packed {logic [12:0] a; logic [15:0] d; logic [1:0] s;} exp_t;
    typedef struct packed {logic [4:0] c; logic [8:0] f; logic [15:0] sw;} row_t;
    localparam row_t ROWS [12] = '{
        '{5'h05, 9'h000, 16'h0005}, '{5'h11, 9'h100, 16'h0011},
        '{5'h1F, 9'h140, 16'h441F}, '{5'h10, 9'h120, 16'h0C10},
        '{5'h12, 9'h000, 16'h1412}, '{5'h03, 9'h100, 16'h1403},
        '{5'h13, 9'h110, 16'h2413}, '{5'h14, 9'h104, 16'h0034},
        '{5'h15, 9'h103, 16'h0115}, '{5'h16, 9'h101, 16'h0216},
        '{5'h01, 9'h008, 16'h0001}, '{5'h07, 9'h080, 16'h1407}};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, msg_ready, msg_done, msg_is_tx;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [4:0] mc, mdc;
    logic [15:0] cw, tt, mdw, bw, txd, mdv, ram_wdata;
    logic [12:0] ptr, ram_addr, p;
    logic [8:0] fl;
    logic rif, bsy, mds, ram_we, rif_seen, busy_seen, timed_out;
    int mismatches = 0, total_checks = 0, nrec = 0;
    exp_t q[$];
    exp_t e;

    always #20 aclk = ~aclk;

    rt_mode_cmd_record_writer dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .msg_done(msg_done), .msg_ready(msg_ready), .msg_is_tx(msg_is_tx),
        .mode_code_field(mc), .cmd_word(cw), .data_pointer(ptr), .time_tag(tt),
        .mode_data_word(mdw), .bit_word(bw), .data_word_seen(fl[8]),
        .extra_word_seen(fl[7]), .data_word_bad(fl[6]), .data_sync_bad(fl[5]),
        .gap_seen(fl[4]), .broadcast(fl[3]), .bus_b(fl[2]), .illegal_bit(fl[1]),
        .per_command_busy(fl[0]), .respond_in_form(rif), .answer_busy(bsy),
        .tx_mode_data(txd), .mode_data_strobe(mds), .mode_data_code(mdc),
        .mode_data_value(mdv), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata));

    mode_cmd_source src (.aclk(aclk), .msg_ready(msg_ready), .respond_in_form(rif),
        .answer_busy(bsy), .msg_done(msg_done), .msg_is_tx(msg_is_tx),
        .mode_code_field(mc), .cmd_word(cw), .data_pointer(ptr), .time_tag(tt),
        .mode_data_word(mdw), .bit_word(bw), .flags(fl), .rif_seen(rif_seen),
        .busy_seen(busy_seen), .timed_out(timed_out));

    // ----
    // Checking and closing
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize

    task automatic stuck(input logic ok);
        if (!ok) begin
            mismatches++;
            summarize();
        end
    endtask : stuck

    always @(negedge aclk) begin
        if (aresetn && ram_we) begin
            if (q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = q.pop_front();
                chk({ram_addr, ram_wdata}, {e.a, e.d});
                if (e.s < 2'd2) chk(mds, e.s[0]);
                if (e.s == 2'd1) chk(mdc, e.d[4:0]);
                if (e.s == 2'd3) chk(mdv, e.d);
            end
        end
    end

    // ----
    // Bus and message tasks
    // ----
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tw, tb;
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        for (n = 0; n < 50 && !tb; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            if (tb) chk(bresp, r);
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        stuck(tb);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ta, tr;
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        for (n = 0; n < 50 && !tr; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            tr = rvalid;
            if (tr) chk({rdata, rresp}, {d, r});
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        stuck(tr);
    endtask : axi_rd

    task automatic rec(input logic tx, input logic [4:0] c, input logic [12:0] pp,
        input logic [15:0] dw, input logic [15:0] cwd, input logic [8:0] f,
        input logic [15:0] sw, input logic [15:0] dx, input int gap);
        logic [1:0] st;
        st = (!tx && c[4]) ? (f == 9'h100 ? 2'd1 : (sw[10] ? 2'd0 : 2'd2)) : 2'd0;
        q.push_back('{pp, sw, st});
        q.push_back('{pp + 13'd1, {3'h5, pp}, 2'd2});
        if (c[4]) q.push_back('{pp + 13'd2, dx, tx ? 2'd2 : 2'd3});
        src.send(tx, c, pp, {3'h5, pp}, dw, cwd, 16'hB17B, f, gap);
        stuck(!timed_out);
        nrec++;
    endtask : rec

    task automatic drain;
        int n;
        for (n = 0; n < 20 && q.size() > 0; n++) @(posedge aclk);
        stuck(q.size() == 0);
    endtask : drain

    // ----
    // Main sequence
    // ----
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({msg_ready, ram_we, mds}, 3'b100);
        for (int i = 0; i < 16; i += 4) axi_rd(8'(i), 32'h0, RESP_OKAY);
        foreach (ROWS[i]) begin
            p = 13'h0100 + 13'(i * 4);
            rec(1'b0, ROWS[i].c, p, 16'h5A00 + 16'(i), 16'h0, ROWS[i].f, ROWS[i].sw,
                16'h5A00 + 16'(i), i % 3);
        end
        drain();
        axi_rd(ADDR_REC_COUNT, 32'(nrec), RESP_OKAY);
        axi_rd(ADDR_LAST_STATUS, 32'h1407, RESP_OKAY);
        axi_wr(ADDR_REC_COUNT, 32'h55, RESP_OKAY);
        axi_rd(ADDR_REC_COUNT, 32'(nrec), RESP_OKAY);
        axi_wr(8'h10, 32'h1, RESP_DECERR);
        axi_rd(8'h10, 32'h0, RESP_DECERR);
        axi_wr(ADDR_CONFIG, 32'h1, RESP_OKAY);
        foreach (ROWS[i]) begin
            if (i < 5) begin
                p = 13'h0200 + 13'(i * 4);
                rec(1'b0, ROWS[i].c | 5'h10, p, 16'h0, 16'h0, 9'h101,
                    {11'h0, ROWS[i].c | 5'h10} | (i < 3 ? 16'h0200 : 16'h0), 16'h0, 1);
                chk({rif_seen, busy_seen}, {i < 3, 1'b1});
            end
        end
        rec(1'b0, 5'h04, 13'h0220, 16'h0, 16'h0, 9'h001, 16'h0004, 16'h0, 1);
        chk(rif_seen, 1'b0);
        axi_wr(ADDR_CONFIG, 32'hA, RESP_OKAY);
        axi_rd(ADDR_CONFIG, 32'hA, RESP_OKAY);
        rec(1'b0, 5'h02, 13'h0300, 16'h0, 16'h0, 9'h018, 16'h2202, 16'h0, 2);
        chk({rif_seen, busy_seen}, 2'b11);
        axi_wr(ADDR_CONFIG, 32'h0, RESP_OKAY);
        rec(1'b1, 5'h10, 13'h0400, 16'h1234, 16'hC0DE, 9'h0, 16'h0010, 16'h1234, 1);
        rec(1'b1, 5'h12, 13'h0404, 16'h1111, 16'h0F0F, 9'h0, 16'h0012, 16'hC0DE, 1);
        rec(1'b1, 5'h13, 13'h0408, 16'h2222, 16'h0, 9'h0, 16'h0013, 16'hB17B, 1);
        rec(1'b1, 5'h15, 13'h040C, 16'h3333, 16'h0, 9'h040, 16'h0015, 16'h3333, 1);
        drain();
        chk(txd, 16'h3333);
        axi_rd(ADDR_TX_DATA, 32'h3333, RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk({msg_ready, ram_we, mds, txd}, {3'b100, 16'h0000});
        axi_rd(ADDR_REC_COUNT, 32'h0, RESP_OKAY);
        axi_rd(ADDR_CONFIG, 32'h0, RESP_OKAY);
        summarize();
    end
endmodule : test_rt_mode_cmd_record_writer
